// file: src/upload_ctrl_defs.svh
// Offsets, field positions and reset values of the upload control register.
// Assumes inclusion by bare name from the package and the design module.
`ifndef UPLOAD_CTRL_DEFS_SVH
`define UPLOAD_CTRL_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define MAIN_CONTROL_SECOND_OFFSET 12'h100
`define RESP_OKAY                  2'h0
`define RESP_SLVERR                2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define MASK_MSB                   31
`define MASK_LSB                   16
`define FLAG_MSB                   15
`define FLAG_LSB                   11
`define LOAD_MSB                   10
`define LOAD_LSB                   0
`define LOAD_TWO_WIRE              0
`define LOAD_EXPANSION_BUS         1
`define LOAD_VIDEO_CHAN1           2
`define LOAD_VIDEO_CHAN2           3
`define LOAD_VIDEO_CHAN3           4
`define LOAD_SCALER_VERTICAL       5
`define LOAD_SCALER_HORIZONTAL     6
`define LOAD_RESERVED              7
`define LOAD_RATIO_SCALER          8
`define LOAD_PORT_A_STREAM         9
`define LOAD_PORT_B_STREAM         10

// Upload bits that exist; position seven is reserved.
`define LOAD_VALID_MASK            11'h77f

// ****************************************************************
// Working register offsets served by each upload group
// ****************************************************************
`define WORK_PORT_INIT             8'h50
`define WORK_PORT_STREAM           8'h54
`define WORK_RATIO_SCALER          8'h58
`define WORK_SCALER_CTRL           8'h5c
`define WORK_SCALER_VSCALE         8'h60
`define WORK_SCALER_VGAIN          8'h64
`define WORK_SCALER_HPRE           8'h68
`define WORK_SCALER_HFINE          8'h6c
`define WORK_BCS_CTRL              8'h70
`define WORK_COLOUR_KEY            8'h74
`define WORK_OUT_FORMAT_CLIP       8'h78
`define WORK_CHAN1_FIRST           8'h00
`define WORK_CHAN1_LAST            8'h14
`define WORK_CHAN2_FIRST           8'h18
`define WORK_CHAN2_LAST            8'h2c
`define WORK_CHAN3_FIRST           8'h30
`define WORK_CHAN3_LAST            8'h44
`define WORK_SHARED                8'h48
`define WORK_EXP_FIRST             8'h7c
`define WORK_EXP_LAST              8'h88
`define WORK_TWO_WIRE_FIRST        8'h8c
`define WORK_TWO_WIRE_LAST         8'h90

// ****************************************************************
// Reset values
// ****************************************************************
`define FLAG_RESET                 5'h00
`define LOAD_RESET                 11'h000

`endif

// file: src/upload_ctrl_pkg.sv
// Types shared by the upload control register and its surroundings.
// Assumes the constants header is on the include path.
package upload_ctrl_pkg;
	`include "upload_ctrl_defs.svh"

	// One sequencer task's request for this register.
	typedef struct packed {
		logic [4:0]  flag_set;
		logic [4:0]  flag_clr;
		logic [10:0] load;
	} seq_req_s;

	// Upload strobes towards the shadow and working registers.
	typedef struct packed {
		logic        port_init;
		logic [10:0] load;
	} load_pulse_s;
endpackage

// file: src/shadow_upload_control_register.sv
// Second main control register: masked writes, sequencer flags and upload triggers.
// Assumes an AXI4-Lite master on clk_sys and a shadow store that reports changed groups.
//
// Overview of operation
// - The upper sixteen bits of a write form a per-bit mask over the lower sixteen bits.
// - The mask bits always read back as zero.
// - Control bit seven is reserved, ignores writes and reads as zero.
// - The five flags in bits fifteen to eleven are set and cleared by software and both tasks.
// - Writing one to an upload bit uploads its changed group; reading it shows pending changes.
// - Bits ten and nine upload the stream settings of the second and first video port.
// - The dual port initial setting is uploaded only when bits nine and ten are set together.
// - Bit eight uploads the binary-ratio scaler control register.
// - Bit six uploads horizontal prescale, fine-scale and brightness/contrast/saturation.
// - Bit five uploads scaler control, vertical scale and gain, colour key, format and clip.
// - Bit four uploads the third video channel and its share of the shared register.
// - Bit three uploads the second video channel and its share of the shared register.
// - Bit two uploads the first video channel and its share of the shared register.
// - Bit one uploads the expansion bus registers and their share of the shared register.
// - Bit zero uploads the two-wire bus registers.
`timescale 1ns/1ps
`include "upload_ctrl_defs.svh"

module shadow_upload_control_register #(
	parameter int ADDR_W = 12
) (
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire upload_ctrl_pkg::seq_req_s  task0_req,
	input  wire upload_ctrl_pkg::seq_req_s  task1_req,
	input  wire logic [10:0]                shadow_changed,
	output logic [4:0]                      seq_flag,
	output upload_ctrl_pkg::load_pulse_s    load_pulse
);
	import upload_ctrl_pkg::*;

	initial begin
		if (ADDR_W < 9 || ADDR_W > 32)
			$error("ADDR_W must hold the register offset");
	end

	// ****************************************************************
	// Functions
	// ****************************************************************
	localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(`MAIN_CONTROL_SECOND_OFFSET);

	function automatic logic is_reg(input logic [ADDR_W-1:0] addr);
		is_reg = (addr[ADDR_W-1:2] == REG_ADDR[ADDR_W-1:2]);
	endfunction

	function automatic logic [15:0] lanes(input logic [1:0] strb);
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// ****************************************************************
	// Write channel
	// ****************************************************************
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_fire;
	logic              w_fire;
	logic              do_write;
	logic              next_aw_held;
	logic              next_w_held;
	logic              next_bvalid;
	logic [ADDR_W-1:0] cur_addr;
	logic [31:0]       cur_data;
	logic [3:0]        cur_strb;

	assign aw_fire      = s_axi_awvalid && s_axi_awready;
	assign w_fire       = s_axi_wvalid && s_axi_wready;
	assign do_write     = (aw_held || aw_fire) && (w_held || w_fire);
	assign next_aw_held = (aw_held || aw_fire) && !do_write;
	assign next_w_held  = (w_held || w_fire) && !do_write;
	assign next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
	assign cur_addr     = aw_held ? aw_addr : s_axi_awaddr;
	assign cur_data     = w_held ? w_data : s_axi_wdata;
	assign cur_strb     = w_held ? w_strb : s_axi_wstrb;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Ready drops while a response is pending so only one write is ever in flight.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (do_write)
				s_axi_bresp <= is_reg(cur_addr) ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// ****************************************************************
	// Masked write decode
	// ****************************************************************
	logic        reg_write;
	logic [15:0] bit_enable;
	logic [15:0] bit_value;
	logic [10:0] sw_load;
	logic [10:0] load_req;

	assign reg_write = do_write && is_reg(cur_addr);
	// A bit is touched only when both its mask lane and its control lane are strobed.
	assign bit_enable = cur_data[`MASK_MSB:`MASK_LSB] & lanes(cur_strb[3:2])
		& lanes(cur_strb[1:0]) & {16{reg_write}};
	assign bit_value  = cur_data[15:0];
	// Upload bits act on a written one only; a written zero does nothing.
	assign sw_load  = bit_enable[`LOAD_MSB:`LOAD_LSB] & bit_value[`LOAD_MSB:`LOAD_LSB];
	assign load_req = (sw_load | task0_req.load | task1_req.load) & `LOAD_VALID_MASK;

	// ****************************************************************
	// Sequencer flags
	// ****************************************************************
	logic [4:0] next_seq_flag;

	always_comb begin
		next_seq_flag = seq_flag;
		next_seq_flag = (next_seq_flag & ~bit_enable[`FLAG_MSB:`FLAG_LSB])
			| (bit_value[`FLAG_MSB:`FLAG_LSB] & bit_enable[`FLAG_MSB:`FLAG_LSB]);
		next_seq_flag = next_seq_flag & ~(task0_req.flag_clr | task1_req.flag_clr);
		// A task setting a flag wins over any clear in the same cycle.
		next_seq_flag = next_seq_flag | task0_req.flag_set | task1_req.flag_set;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			seq_flag <= `FLAG_RESET;
		else
			seq_flag <= next_seq_flag;
	end

	// ****************************************************************
	// Upload strobes and pending changes
	// ****************************************************************
	logic [10:0] pending;

	// Each strobe bit drives one group of working registers:
	// bit 10 port B stream, 9 port A stream, 8 ratio scaler, 6 horizontal scaler and
	// colour controls, 5 vertical scaler, key, format and clip, 4..2 video channels
	// three to one with their share of the shared register, 1 expansion bus with its
	// share, 0 two-wire bus.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			load_pulse <= '0;
		end else begin
			load_pulse.load      <= load_req;
			load_pulse.port_init <= load_req[`LOAD_PORT_A_STREAM]
				&& load_req[`LOAD_PORT_B_STREAM];
		end
	end

	// A change that lands in the upload cycle stays pending, since the set wins.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			pending <= `LOAD_RESET;
		else
			pending <= ((pending & ~load_req) | shadow_changed) & `LOAD_VALID_MASK;
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	logic ar_fire;
	logic next_rvalid;

	assign ar_fire     = s_axi_arvalid && s_axi_arready;
	assign next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (ar_fire) begin
				if (is_reg(s_axi_araddr)) begin
					s_axi_rdata <= {16'h0000, seq_flag, pending};
					s_axi_rresp <= `RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end
		end
	end
endmodule

// file: sim/upload_ctrl_props.sv
// Concurrent checks on the ports of the upload control register.
// Assumes it is bound onto shadow_upload_control_register.
`timescale 1ns/1ps
module upload_ctrl_props (
	input wire logic                         clk_sys,
	input wire logic                         reset_n,
	input wire logic                         s_axi_bvalid,
	input wire logic [1:0]                   s_axi_bresp,
	input wire logic                         s_axi_rvalid,
	input wire logic [1:0]                   s_axi_rresp,
	input wire logic [31:0]                  s_axi_rdata,
	input wire upload_ctrl_pkg::seq_req_s    task0_req,
	input wire upload_ctrl_pkg::seq_req_s    task1_req,
	input wire logic [4:0]                   seq_flag,
	input wire upload_ctrl_pkg::load_pulse_s load_pulse
);
	import upload_ctrl_pkg::*;
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_mask_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("mask bits read back nonzero");
	a_reserved_read_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[7])
		else $error("reserved bit read back nonzero");
	a_reserved_no_load: assert property (load_pulse.load[7] == 1'b0)
		else $error("reserved upload strobe raised");
	a_init_needs_pair: assert property (load_pulse.port_init |-> &load_pulse.load[10:9])
		else $error("port init without both port uploads");
	a_pair_gives_init: assert property (&load_pulse.load[10:9] |-> load_pulse.port_init)
		else $error("both port uploads without port init");
	a_flag_read_match: assert property ($rose(s_axi_rvalid) && s_axi_rresp == 2'h0
		|-> s_axi_rdata[15:11] == $past(seq_flag)) else $error("read flags differ");
	a_flag_change_cause: assert property ($changed(seq_flag) |->
		($rose(s_axi_bvalid) && s_axi_bresp == 2'h0) || $past(|{task0_req.flag_set,
		task0_req.flag_clr, task1_req.flag_set, task1_req.flag_clr}))
		else $error("flags changed without a cause");
	a_load_cause: assert property (|load_pulse.load |-> ($rose(s_axi_bvalid) &&
		s_axi_bresp == 2'h0) || $past(|(task0_req.load | task1_req.load)))
		else $error("upload strobe without a request");
endmodule

bind shadow_upload_control_register upload_ctrl_props upload_ctrl_props_i (.clk_sys, .reset_n,
	.s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .task0_req,
	.task1_req, .seq_flag, .load_pulse);

// file: sim/testbench.sv
// Self-checking bench for the upload control register over AXI4-Lite.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
	import upload_ctrl_pkg::*;
	logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_state;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	seq_req_s    task0_req, task1_req;
	logic [10:0] shadow_changed;
	logic [4:0]  seq_flag;
	load_pulse_s load_pulse;
	logic [33:0] resp_q[$];
	logic [11:0] pulse_q[$];
	int          failures, samples_checked;

	shadow_upload_control_register shadow_upload_control_register_i (.clk_sys, .reset_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .task0_req, .task1_req, .shadow_changed, .seq_flag,
		.load_pulse);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	function automatic logic [31:0] lfsr_next();
		lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h8020_0003)};
		return lfsr_state;
	endfunction
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [33:0] got);
		cmp(got, resp_q.size() > 0 ? resp_q.pop_front() : 34'h3_ffff_ffff);
	endtask
	task automatic chk_pulse(input logic [11:0] got);
		cmp({22'h0, got}, pulse_q.size() > 0 ? {22'h0, pulse_q.pop_front()} : 34'h3_ffff_ffff);
	endtask
	// Holds each channel until its own ready; bready stays up until the response.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		n = 0;
		resp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		if (n >= 50) failures++;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
		int n;
		n = 0;
		resp_q.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		if (n >= 50) failures++;
		@(posedge clk_sys);
	endtask
	task automatic mw(input logic [15:0] m, input logic [15:0] c);
		wr(12'h100, {m, c}, 4'hf, 2'h0);
	endtask
	task automatic test_done;
		if (resp_q.size() > 0 || pulse_q.size() > 0) failures++;
		$display("counts: failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Clock, monitor, watchdog and sequence
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (s_axi_bvalid && s_axi_bready) chk_resp({s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready) chk_resp({s_axi_rresp, s_axi_rdata});
		if (reset_n && load_pulse !== 12'h000) chk_pulse(load_pulse);
	end
	// About twenty-six transfers of a few cycles each; this leaves a wide margin.
	initial begin
		#20000;
		failures++;
		test_done;
	end
	initial begin
		logic [31:0] rnd;
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{task0_req, task1_req, shadow_changed} = '0;
		lfsr_state = 32'hb16d;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(12'h100, 2'h0, 32'h0000_0000);
		pulse_q.push_back(12'hf7f);
		mw(16'hffff, 16'hffff);
		rd(12'h100, 2'h0, 32'h0000_f800);
		mw(16'h1000, 16'hefff);
		rd(12'h100, 2'h0, 32'h0000_e800);
		for (int i = 0; i < 11; i++) begin
			if (i != 7) pulse_q.push_back(12'h001 << i);
			mw(16'h0001 << i, 16'h0001 << i);
		end
		rnd = lfsr_next();
		shadow_changed <= rnd[10:0];
		@(posedge clk_sys);
		shadow_changed <= 11'h000;
		@(posedge clk_sys);
		mw(16'h0000, rnd[15:0]);
		rd(12'h100, 2'h0, {16'h0, 5'h1d, rnd[10:0] & 11'h77f});
		pulse_q.push_back(12'hf7f);
		mw(16'h07ff, 16'h07ff);
		rd(12'h100, 2'h0, 32'h0000_e800);
		wr(12'h100, 32'hffff_ffff, 4'h3, 2'h0);
		wr(12'h100, 32'hffff_ffff, 4'hc, 2'h0);
		task0_req <= '{flag_set: 5'h02, flag_clr: 5'h00, load: 11'h600};
		task1_req <= '{flag_set: 5'h00, flag_clr: 5'h03, load: 11'h000};
		pulse_q.push_back(12'he00);
		@(posedge clk_sys);
		task0_req <= '0;
		task1_req <= '0;
		@(posedge clk_sys);
		rd(12'h100, 2'h0, 32'h0000_f000);
		wr(12'h104, 32'hffff_ffff, 4'hf, 2'h2);
		rd(12'h104, 2'h2, 32'h0000_0000);
		rd(12'h100, 2'h0, 32'h0000_f000);
		cmp({29'h0, seq_flag}, 34'h0_0000_001e);
		test_done;
	end
endmodule
